// ==== hw/dfrs_top.sv ====
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "dfrs_map.svh"
// Operation
// - ready only when up to speed, heads loaded, no fault
// - read and write together raise fault, latch read-write flag
// - write gate without ac write current raises fault
// - write without ac or dc current latches write fault flag
// - more than one head selected raises fault, latches head flag
// - read or write while off cylinder raises fault, latches flag
// - low voltage on any rail raises fault, latches voltage flag
// - no dibit for 350 ms with heads loaded raises fault
// - fault clear resets summary fault, leaves maintenance flags
// - unit maintenance blocks the unit selected response
// - unit number compared with controller select code
// - write protect disables writer and shows protected state
// - start spins up only with pack, cover closed, breakers on
// - start off unloads heads then stops spindle
// - head loading begins only after spindle reaches speed
// - loading done at track 0; commands only afterwards
// - up to speed status enables head loading
module dfrs_top (
  input  wire logic                 clk,      // 200 MHz drive clock
  input  wire logic                 rst,      // sync reset, high
  input  wire logic                 psel,     // apb select
  input  wire logic                 penable,  // apb enable
  input  wire logic                 pwrite,   // apb direction
  input  wire logic [11:0]          paddr,    // apb byte address
  input  wire logic [31:0]          pwdata,   // apb write data
  output logic      [31:0]          prdata,   // apb read data
  output logic                      pready,   // apb ready
  output logic                      pslverr,  // apb error
  input  wire dfrs_pkg::dfrs_sense_t sense,   // drive sense inputs
  input  wire dfrs_pkg::dfrs_mech_t  mech,    // interlocks and status
  input  wire logic [3:0]           sel_code, // controller unit code
  input  wire logic                 sel_req,  // controller select
  output dfrs_pkg::dfrs_act_t       act,      // actuator commands
  output logic                      unit_sel, // unit selected reply
  output logic                      ready,    // ready to controller
  output logic                      fault,    // summary fault
  output logic                      wprot_ind // write protected lamp
);
  import dfrs_pkg::*;

  logic [4:0]  ctrl;
  logic [3:0]  unit_num;
  wire  [4:0]  mflt;
  dfrs_seq_t   state;
  logic        loaded;
  logic        dibit_lost;
  logic        start_q;
  logic        multi_head;
  logic        c_rw, c_ac, c_wr, c_head, c_cyl, c_volt;
  logic        any_cause;
  logic        wr_stb, rd_stb, fclr, mclr;

  // apb decode: zero wait state, reads take flip-flop data
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign fclr   = wr_stb && paddr == `DFRS_CTRL_OFF
                  && pwdata[`DFRS_CTRL_FCLR];
  assign mclr   = wr_stb && paddr == `DFRS_CTRL_OFF
                  && pwdata[`DFRS_CTRL_MCLR];

  // control and unit number registers; clear bits are self-clearing
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl     <= `DFRS_CTRL_RST;
      unit_num <= `DFRS_UNIT_RST;
    end else if (wr_stb && paddr == `DFRS_CTRL_OFF) begin
      ctrl <= {2'b00, pwdata[2:0]};
    end else if (wr_stb && paddr == `DFRS_UNIT_OFF) begin
      unit_num <= pwdata[3:0];
    end
  end

  // read data registered in setup so it is stable in the access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        `DFRS_CTRL_OFF: prdata <= {27'h0, ctrl};
        `DFRS_STAT_OFF: prdata <= {24'h0, 1'(state == DFRS_READY_ST),
                                    loaded, mech.up_to_speed, fault,
                                    ready, unit_sel, wprot_ind,
                                    act.spindle_on};
        `DFRS_MFLT_OFF: prdata <= {27'h0, mflt};
        `DFRS_UNIT_OFF: prdata <= {28'h0, unit_num};
        default: begin
          prdata  <= 32'h0;
          pslverr <= 1'b1; // unmapped
        end
      endcase
      if (!rd_stb && paddr != `DFRS_CTRL_OFF && paddr != `DFRS_STAT_OFF
          && paddr != `DFRS_MFLT_OFF && paddr != `DFRS_UNIT_OFF)
        prdata <= 32'h0;
    end
  end

  // registered copy of start; the sequencer does not use it and acts on the start level
  always_ff @(posedge clk) begin
    if (rst) start_q <= 1'b0;
    else     start_q <= ctrl[`DFRS_CTRL_START];
  end

  // spindle and head sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DFRS_IDLE;
    end else begin
      case (state)
        DFRS_IDLE:
          if (ctrl[`DFRS_CTRL_START] && mech.pack_present
              && mech.cover_closed && mech.breakers_on)
            state <= DFRS_SPIN_UP;
        DFRS_SPIN_UP:
          if (!ctrl[`DFRS_CTRL_START]) state <= DFRS_UNLOAD;
          else if (mech.up_to_speed) state <= DFRS_LOAD;
        DFRS_LOAD:
          if (!ctrl[`DFRS_CTRL_START]) state <= DFRS_UNLOAD;
          else if (mech.on_track0) state <= DFRS_READY_ST;
        DFRS_READY_ST:
          if (!ctrl[`DFRS_CTRL_START]) state <= DFRS_UNLOAD;
        DFRS_UNLOAD:
          if (mech.heads_unloaded) state <= DFRS_STOP;
        DFRS_STOP:
          if (!mech.up_to_speed) state <= DFRS_IDLE;
        default: state <= DFRS_IDLE;
      endcase
    end
  end

  assign loaded = (state == DFRS_READY_ST);

  // spindle and head commands follow the sequencer state, write enable the protect bit
  always_ff @(posedge clk) begin
    if (rst) begin
      act <= '0;
    end else begin
      act.spindle_on   <= (state == DFRS_SPIN_UP || state == DFRS_LOAD
                           || state == DFRS_READY_ST
                           || state == DFRS_UNLOAD);
      act.load_heads   <= (state == DFRS_LOAD);
      act.unload_heads <= (state == DFRS_UNLOAD);
      act.write_enable <= !ctrl[`DFRS_CTRL_PROTECT];
    end
  end

  // fault causes, combined per cycle
  always_comb begin
    multi_head = 1'b0;
    for (int i = 0; i < 5; i++) begin
      for (int j = i + 1; j < 5; j++) begin
        if (sense.head_sel[i] && sense.head_sel[j]) multi_head = 1'b1;
      end
    end
  end
  assign c_rw   = sense.read_sel && sense.write_gate;
  assign c_ac   = sense.write_gate && !sense.ac_wr_cur;
  assign c_wr   = sense.write_gate
                  && (!sense.ac_wr_cur || !sense.dc_wr_cur);
  assign c_head = multi_head;
  assign c_cyl  = (sense.read_sel || sense.write_gate)
                  && !sense.on_cyl;
  assign c_volt = |sense.low_volt;
  assign any_cause = c_rw | c_ac | c_head | c_cyl | c_volt
                     | dibit_lost;

  dfrs_dibit_watch u_dibit (
    .clk     (clk),
    .rst     (rst),
    .armed   (loaded),
    .dibit   (sense.dibit),
    .timeout (dibit_lost)
  );

  // summary fault: a new cause wins over fault clear
  always_ff @(posedge clk) begin
    if (rst)            fault <= 1'b0;
    else if (any_cause) fault <= 1'b1;
    else if (fclr)      fault <= 1'b0;
  end

  // maintenance flags per bit; fault clear does not touch them
  logic [4:0] mset;
  assign mset = {c_volt, c_cyl, c_rw, c_head, c_wr};
  // one flop per flag keeps each bit with a single driver
  for (genvar k = 0; k < 5; k++) begin : g_mflt
    logic flag;
    always_ff @(posedge clk) begin
      if (rst)          flag <= 1'b0;
      else if (mset[k]) flag <= 1'b1;
      else if (mclr)    flag <= 1'b0;
    end
    assign mflt[k] = flag;
  end

  // interface responses
  always_ff @(posedge clk) begin
    if (rst) begin
      ready     <= 1'b0;
      unit_sel  <= 1'b0;
      wprot_ind <= 1'b0;
    end else begin
      ready     <= mech.up_to_speed && loaded && !fault
                   && !any_cause;
      unit_sel  <= sel_req && sel_code == unit_num
                   && !ctrl[`DFRS_CTRL_MAINT];
      wprot_ind <= ctrl[`DFRS_CTRL_PROTECT];
    end
  end

  a_ready_no_fault: assert property (@(posedge clk) disable iff (rst)
    ready |-> $past(mech.up_to_speed) && $past(loaded) && !$past(fault))
    else $error("ready without speed or loaded heads");
  a_rw_sets_fault: assert property (@(posedge clk) disable iff (rst)
    c_rw |=> fault && mflt[`DFRS_MF_RW])
    else $error("read write conflict not flagged");
  a_ac_sets_fault: assert property (@(posedge clk) disable iff (rst)
    c_ac |=> fault)
    else $error("missing ac current not faulted");
  a_write_flag_set: assert property (@(posedge clk) disable iff (rst)
    c_wr |=> mflt[`DFRS_MF_WRITE])
    else $error("write fault flag not latched");
  a_head_fault_set: assert property (@(posedge clk) disable iff (rst)
    multi_head |=> fault && mflt[`DFRS_MF_HEAD])
    else $error("head select fault not latched");
  a_cyl_fault_set: assert property (@(posedge clk) disable iff (rst)
    c_cyl |=> fault && mflt[`DFRS_MF_CYL])
    else $error("off cylinder fault not latched");
  a_volt_fault_set: assert property (@(posedge clk) disable iff (rst)
    c_volt |=> fault && mflt[`DFRS_MF_VOLT])
    else $error("voltage fault not latched");
  // a write flag set in the same cycle is a legal flag change
  a_clear_keeps_flags: assert property (@(posedge clk) disable iff (rst)
    fclr && !mclr && !any_cause && !c_wr
    |=> !fault && mflt == $past(mflt))
    else $error("fault clear misbehaved");
  a_maint_blocks_sel: assert property (@(posedge clk) disable iff (rst)
    ctrl[`DFRS_CTRL_MAINT] |=> !unit_sel)
    else $error("selected during unit maintenance");
  a_load_after_speed: assert property (@(posedge clk) disable iff (rst)
    state == DFRS_SPIN_UP && !mech.up_to_speed |=> state != DFRS_LOAD)
    else $error("loading before speed");
endmodule

// ==== hw/dfrs_map.svh ====
`ifndef DFRS_MAP_SVH
`define DFRS_MAP_SVH
// register byte offsets
`define DFRS_CTRL_OFF       12'h000
`define DFRS_STAT_OFF       12'h004
`define DFRS_MFLT_OFF       12'h008
`define DFRS_UNIT_OFF       12'h00C
// control bit positions
`define DFRS_CTRL_START     0
`define DFRS_CTRL_PROTECT   1
`define DFRS_CTRL_MAINT     2
`define DFRS_CTRL_FCLR      3
`define DFRS_CTRL_MCLR      4
// maintenance fault bit positions
`define DFRS_MF_WRITE       0
`define DFRS_MF_HEAD        1
`define DFRS_MF_RW          2
`define DFRS_MF_CYL         3
`define DFRS_MF_VOLT        4
// reset values
`define DFRS_CTRL_RST       5'h00
`define DFRS_UNIT_RST       4'h0
// timing
`define DFRS_CLK_MHZ        200
`define DFRS_DIBIT_MS       350
`define DFRS_DIBIT_CYC      (`DFRS_DIBIT_MS * 1000 * `DFRS_CLK_MHZ)
`endif

// ==== hw/dfrs_pkg.sv ====
package dfrs_pkg;
  // spindle and head sequencing states
  typedef enum logic [2:0] {
    DFRS_IDLE,
    DFRS_SPIN_UP,
    DFRS_LOAD,
    DFRS_READY_ST,
    DFRS_UNLOAD,
    DFRS_STOP
  } dfrs_seq_t;

  // drive sense inputs
  typedef struct packed {
    logic       read_sel;
    logic       write_gate;
    logic       ac_wr_cur;
    logic       dc_wr_cur;
    logic [4:0] head_sel;
    logic       on_cyl;
    logic [2:0] low_volt;
    logic       dibit;
  } dfrs_sense_t;

  // mechanical interlocks and status
  typedef struct packed {
    logic pack_present;
    logic cover_closed;
    logic breakers_on;
    logic up_to_speed;
    logic on_track0;
    logic heads_unloaded;
  } dfrs_mech_t;

  // actuator commands
  typedef struct packed {
    logic spindle_on;
    logic load_heads;
    logic unload_heads;
    logic write_enable;
  } dfrs_act_t;
endpackage

// ==== hw/dfrs_dibit_watch.sv ====
`timescale 1ns/1ps
`include "dfrs_map.svh"
module dfrs_dibit_watch #(
  parameter int unsigned LIMIT = `DFRS_DIBIT_CYC
) (
  input  wire logic clk,      // drive clock
  input  wire logic rst,      // sync reset
  input  wire logic armed,    // heads loaded
  input  wire logic dibit,    // servo dibit pulse
  output logic      timeout   // one-cycle loss pulse
);
  logic [26:0] cnt;

  // count quiet cycles while loaded; fire once per loss interval
  always_ff @(posedge clk) begin
    if (rst || !armed || dibit) begin
      cnt     <= 27'h0;
      timeout <= 1'b0;
    end else if (cnt == 27'(LIMIT - 1)) begin
      cnt     <= 27'h0;
      timeout <= 1'b1;
    end else begin
      cnt     <= cnt + 27'h1;
      timeout <= 1'b0;
    end
  end

  a_dibit_quiet_count: assert property (@(posedge clk) disable iff (rst)
    timeout |-> $past(armed) && !$past(dibit))
    else $error("dibit timeout without quiet loaded interval");
endmodule

// ==== tb/dfrs_mech_model.sv ====
`timescale 1ns/1ps
// spindle and carriage stand-in that follows the actuator commands
module dfrs_mech_model
  import dfrs_pkg::*;
#(
  parameter int SPIN = 20, // cycles to reach speed
  parameter int MOVE = 6   // cycles between carriage stops
) (
  input  wire logic       clk,  // drive clock
  input  wire logic       rst,  // sync reset
  input  wire dfrs_act_t  act,  // actuator commands
  input  wire logic [2:0] ilk,  // pack, cover, breakers
  output dfrs_mech_t      mech  // sensed status
);
  int spd;
  int hp;
  // speed ramps while powered and coasts down otherwise
  always @(posedge clk) begin
    if (rst) spd <= 0;
    else if (act.spindle_on) spd <= (spd < SPIN) ? spd + 1 : SPIN;
    else spd <= (spd > 0) ? spd - 1 : 0;
  end
  // losing speed retracts the heads, so a spin down never crashes
  always @(posedge clk) begin
    if (rst) hp <= 0;
    else if (act.unload_heads || spd != SPIN) hp <= (hp > 0) ? hp - 1 : 0;
    else if (act.load_heads) hp <= (hp < MOVE) ? hp + 1 : MOVE;
  end
  // heads at rest on track 0 once fully travelled
  assign mech = {ilk, spd == SPIN, hp == MOVE, hp == 0};
endmodule

// ==== tb/drive_fault_and_ready_status_test.sv ====
`timescale 1ns/1ps
`include "dfrs_map.svh"
module drive_fault_and_ready_status_test;
  import dfrs_pkg::*;
  localparam logic [31:0] ST = 32'h1 << `DFRS_CTRL_START;
  localparam logic [31:0] PR = 32'h1 << `DFRS_CTRL_PROTECT;
  localparam logic [31:0] MT = 32'h1 << `DFRS_CTRL_MAINT;
  localparam logic [31:0] FC = 32'h1 << `DFRS_CTRL_FCLR;
  localparam logic [31:0] MC = 32'h1 << `DFRS_CTRL_MCLR;
  localparam logic [4:0]  FLG [6] = '{5'h04, 5'h01, 5'h01, 5'h02, 5'h08, 5'h10};
  localparam logic        EF [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, unit_sel, ready, fault, wprot_ind;
  logic [3:0]  sel_code = 4'h0;
  logic        sel_req = 1'b0;
  logic [2:0]  ilk = 3'b111;
  logic [3:0]  dcnt = 4'h0;
  dfrs_sense_t sv, base, sense;
  dfrs_mech_t  mech;
  dfrs_act_t   act;
  logic [32:0] exp_q[$];
  int          error_cnt = 0;
  int          num_checks = 0;

  always #2.5 clk = ~clk;
  // steady servo pulses keep the loss timer quiet
  always @(posedge clk) dcnt <= dcnt + 4'h1;
  assign sense = {sv[13:1], dcnt == 4'h0};

  dfrs_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .mech(mech),
    .sel_code(sel_code), .sel_req(sel_req), .act(act),
    .unit_sel(unit_sel), .ready(ready), .fault(fault),
    .wprot_ind(wprot_ind));
  dfrs_mech_model #(.SPIN(20), .MOVE(6)) model (.clk(clk), .rst(rst),
    .act(act), .ilk(ilk), .mech(mech));

  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // idle cycle after each transfer keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the slave's answer
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return ready;
      1: return act.spindle_on;
      default: return act.unload_heads;
    endcase
  endfunction

  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 300 && sig(k) !== v; i++) @(posedge clk);
  endtask

  // each completed read is matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) check("read_note", 33'h1, 33'h0);
      else check("read_data", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // hang guard, far beyond the expected run
  initial begin
    #(20000 * 5);
    error_cnt++;
    end_of_test();
  end

  initial begin
    dfrs_sense_t c;
    logic [4:0]  mf;
    logic [3:0]  u;
    base = '0;
    base.head_sel = 5'h01;
    base.on_cyl = 1'b1;
    sv = base;
    mf = 5'h00;
    void'($urandom(32'h3d1a));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("fault_rst", fault, 1'b0);
    rd(`DFRS_CTRL_OFF, 33'h0);
    rd(`DFRS_UNIT_OFF, 33'h0);
    rd(`DFRS_MFLT_OFF, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    // open cover must block the spindle
    ilk <= 3'b101;
    apb(1'b1, `DFRS_CTRL_OFF, ST);
    repeat (10) @(posedge clk);
    check("spin_open", act.spindle_on, 1'b0);
    ilk <= 3'b111;
    wt(1, 1'b1);
    check("spin_closed", act.spindle_on, 1'b1);
    repeat (10) @(posedge clk);
    check("load_early", act.load_heads, 1'b0);
    wt(0, 1'b1);
    check("ready_up", ready, 1'b1);
    check("at_track0", mech.on_track0, 1'b1);
    rd(`DFRS_STAT_OFF, 33'h0E9);
    // unit number against select code, then maintenance and protect
    u = 4'($urandom);
    apb(1'b1, `DFRS_UNIT_OFF, {28'h0, u});
    rd(`DFRS_UNIT_OFF, {29'h0, u});
    sel_req <= 1'b1;
    sel_code <= u;
    repeat (3) @(posedge clk);
    check("sel_match", unit_sel, 1'b1);
    sel_code <= ~u;
    repeat (3) @(posedge clk);
    check("sel_other", unit_sel, 1'b0);
    sel_code <= u;
    apb(1'b1, `DFRS_CTRL_OFF, ST | MT | PR | FC);
    rd(`DFRS_CTRL_OFF, {1'b0, ST | MT | PR});
    check("sel_maint", unit_sel, 1'b0);
    check("prot_lamp", wprot_ind, 1'b1);
    check("prot_wren", act.write_enable, 1'b0);
    apb(1'b1, `DFRS_CTRL_OFF, ST);
    repeat (3) @(posedge clk);
    check("sel_back", unit_sel, 1'b1);
    check("prot_off", wprot_ind, 1'b0);
    // every fault cause except dibit loss, cleared in turn; flags accumulate
    for (int k = 0; k < 6; k++) begin
      c = base;
      case (k)
        0: {c.read_sel, c.write_gate, c.ac_wr_cur, c.dc_wr_cur} = 4'hF;
        1: {c.write_gate, c.dc_wr_cur} = 2'b11;
        2: {c.write_gate, c.ac_wr_cur} = 2'b11;
        3: c.head_sel = 5'h03 << ($urandom % 4);
        4: {c.read_sel, c.on_cyl} = 2'b10;
        default: c.low_volt = 3'(($urandom % 7) + 1);
      endcase
      sv <= c;
      repeat (2) @(posedge clk);
      sv <= base;
      repeat (3) @(posedge clk);
      mf = mf | FLG[k];
      check("fault_set", fault, EF[k]);
      check("ready_flt", ready, !EF[k]);
      rd(`DFRS_MFLT_OFF, {28'h0, mf});
      apb(1'b1, `DFRS_CTRL_OFF, ST | FC);
      @(posedge clk);
      check("fault_clr", fault, 1'b0);
      wt(0, 1'b1);
      check("ready_back", ready, 1'b1);
    end
    rd(`DFRS_MFLT_OFF, {28'h0, mf});
    apb(1'b1, `DFRS_CTRL_OFF, ST | MC);
    rd(`DFRS_MFLT_OFF, 33'h0);
    // power off: unload first, spindle stops after
    apb(1'b1, `DFRS_CTRL_OFF, 32'h0);
    wt(2, 1'b1);
    check("spin_hold", act.spindle_on, 1'b1);
    @(posedge clk);
    check("ready_off", ready, 1'b0);
    wt(1, 1'b0);
    check("spin_stop", act.spindle_on, 1'b0);
    check("unloaded", mech.heads_unloaded, 1'b1);
    end_of_test();
  end
endmodule
